// ### design/reset_and_window_watchdog.sv
// Power-on reset sequencer and window watchdog of a dual regulator
//
// What this block does
// R1 - Low supply good: hold reset low for the reset delay, 8 ms fast.
// R2 - After delay, release reset only once high supply is also good.
// R3 - Supply below threshold longer than reaction time pulls reset low.
// R4 - Timebase is a divided clock; select pin picks fast or slow timing.
// R5 - Low level on timebase select disables the watchdog entirely.
// R6 - Reset rising starts a 32 ms ignore window; triggers are ignored.
// R7 - Open window follows; a valid trigger starts a closed window at once.
// R8 - Trigger inside the closed window is premature and forces reset.
// R9 - Closed window end reopens; no trigger in 32 ms forces reset.
// R10 - Trigger is two high then two low samples, 0.25 ms apart fast, 1 ms slow.
// R11 - Trigger whose last low sample lands in open window is correct.
// R12 - Closed window 32 ms fast; window and delay times four times longer when slow.
// R13 - After watchdog reset, hold reset for delay, restart at ignore.
module reset_and_window_watchdog
  import wd_pkg::*;
#(
  parameter int P_SAMPLE_CYCLES = wd_pkg::SAMPLE_CYCLES
)
(
  input  wire logic                     i_clk,
  input  wire logic                     i_resetn,
  input  wire wd_pkg::supply_status_s   i_supply,
  input  wire wd_pkg::timebase_select_s i_timebase_select,
  input  wire logic                     i_wd_trigger_in,
  output logic                          o_reset_out,
  output wd_pkg::wd_state_e             o_window_state,
  output wd_pkg::wd_fault_s             o_wd_fault,
  output logic                          o_power_fail
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  localparam int PIN_W = 5;

  logic [1:0]            rst_sync_reg;
  logic                  rst_n;
  logic [PIN_W-1:0]      pin_meta_reg;
  logic [PIN_W-1:0]      pin_sync_reg;
  logic                  low_good;
  logic                  high_good;
  logic                  tb_off;
  logic                  tb_fast;
  logic                  trig_level;
  logic [PRESCALE_W-1:0] prescale_reg;
  logic [PRESCALE_W-1:0] prescale_limit;
  logic                  tick_reg;
  logic [REACT_W-1:0]    low_bad_cnt_reg;
  logic [REACT_W-1:0]    high_bad_cnt_reg;
  logic                  low_fail_reg;
  logic                  high_fail_reg;
  logic                  trigger;
  wd_state_e             state_reg;
  logic [TICK_W-1:0]     win_cnt_reg;
  logic                  reset_out_reg;
  wd_fault_s             fault_reg;
  logic                  power_fail_reg;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // True on the tick that completes a window of the given length
  function automatic logic window_done(
    input logic              tick,
    input logic [TICK_W-1:0] cnt,
    input logic [TICK_W-1:0] len
  );
    window_done = tick && (cnt == len - 8'h01);
  endfunction : window_done

  // Step a bad-supply filter counter, saturating at the reaction time
  function automatic logic [REACT_W-1:0] filter_step(
    input logic               good,
    input logic [REACT_W-1:0] cnt
  );
    if (good) begin
      filter_step = 12'h000;
    end else if (cnt == REACTION_CYCLES) begin
      filter_step = cnt;
    end else begin
      filter_step = cnt + 12'h001;
    end
  endfunction : filter_step

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  // Assert at once, release two edges later in step with the clock
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_reg[1];

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  // All pins come from outside the clock; only the second stage is read
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_reg <= 5'h00;
      pin_sync_reg <= 5'h00;
    end else begin
      pin_meta_reg <= {i_supply.low_supply_good,
                       i_supply.high_supply_good,
                       i_timebase_select.wd_off,
                       i_timebase_select.fast,
                       i_wd_trigger_in};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  assign low_good   = pin_sync_reg[4];
  assign high_good  = pin_sync_reg[3];
  assign tb_off     = pin_sync_reg[2];
  assign tb_fast    = pin_sync_reg[1];
  assign trig_level = pin_sync_reg[0];

  // ---------------------------------------------------------------
  // Timebase prescaler
  // ---------------------------------------------------------------
  // Fast timing divides by the sample period, slow by four times that
  assign prescale_limit = tb_fast
    ? PRESCALE_W'(P_SAMPLE_CYCLES - 1)                   // R4
    : PRESCALE_W'(P_SAMPLE_CYCLES * SLOW_FACTOR - 1);    // R12

  // Free running, so a window may start up to one tick early in phase
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      prescale_reg <= 20'h00000;
      tick_reg     <= 1'b0;
    end else if (prescale_reg >= prescale_limit) begin
      prescale_reg <= 20'h00000;
      tick_reg     <= 1'b1;                              // R4
    end else begin
      prescale_reg <= prescale_reg + 20'h00001;
      tick_reg     <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Supply fail filters
  // ---------------------------------------------------------------
  // Glitches shorter than the reaction time never reach the fail flag
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_bad_cnt_reg  <= 12'h000;
      high_bad_cnt_reg <= 12'h000;
      low_fail_reg     <= 1'b1;
      high_fail_reg    <= 1'b1;
    end else begin
      low_bad_cnt_reg  <= filter_step(low_good, low_bad_cnt_reg);
      high_bad_cnt_reg <= filter_step(high_good, high_bad_cnt_reg);
      low_fail_reg     <= !low_good &&
                          (low_bad_cnt_reg == REACTION_CYCLES);  // R3
      high_fail_reg    <= !high_good &&
                          (high_bad_cnt_reg == REACTION_CYCLES); // R3
    end
  end

  // ---------------------------------------------------------------
  // Trigger decode
  // ---------------------------------------------------------------
  trigger_sampler u_trigger_sampler (
    .i_clk           (i_clk),
    .i_rst_n         (rst_n),
    .i_sample_tick   (tick_reg),
    .i_trigger_level (trig_level),
    .o_trigger       (trigger)
  );

  // ---------------------------------------------------------------
  // Reset sequencer and window state machine
  // ---------------------------------------------------------------
  // Window changes happen on the tick cycle; the trigger pulse lands
  // one cycle later, so a sample taken on the closing tick counts as
  // the open window's first
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg     <= ST_WAIT_LOW;
      win_cnt_reg   <= 8'h00;
      reset_out_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_WAIT_LOW: begin
          reset_out_reg <= 1'b0;
          win_cnt_reg   <= 8'h00;
          if (low_good) begin
            state_reg <= ST_DELAY;                       // R1
          end
        end
        ST_DELAY: begin
          reset_out_reg <= 1'b0;                         // R1
          if (low_fail_reg) begin
            state_reg <= ST_WAIT_LOW;
          end else if (window_done(tick_reg, win_cnt_reg,
                                   RESET_DELAY_TICKS)) begin
            state_reg   <= ST_CHECK_HIGH;                // R2
            win_cnt_reg <= 8'h00;
          end else if (tick_reg) begin
            win_cnt_reg <= win_cnt_reg + 8'h01;
          end
        end
        ST_CHECK_HIGH: begin
          win_cnt_reg <= 8'h00;
          if (low_fail_reg) begin
            state_reg <= ST_WAIT_LOW;
          end else if (high_good && low_good) begin
            reset_out_reg <= 1'b1;                       // R2
            state_reg     <= tb_off ? ST_WD_OFF          // R5
                                    : ST_IGNORE;         // R6
          end
        end
        ST_IGNORE: begin
          if (low_fail_reg || high_fail_reg) begin
            reset_out_reg <= 1'b0;                       // R3
            state_reg     <= ST_WAIT_LOW;
          end else if (tb_off) begin
            state_reg <= ST_WD_OFF;                      // R5
          end else if (window_done(tick_reg, win_cnt_reg,
                                   IGNORE_TICKS)) begin
            state_reg   <= ST_OPEN;                      // R7
            win_cnt_reg <= 8'h00;
          end else if (tick_reg) begin
            win_cnt_reg <= win_cnt_reg + 8'h01;          // R6
          end
        end
        ST_OPEN: begin
          if (low_fail_reg || high_fail_reg) begin
            reset_out_reg <= 1'b0;                       // R3
            state_reg     <= ST_WAIT_LOW;
          end else if (tb_off) begin
            state_reg <= ST_WD_OFF;                      // R5
          end else if (trigger) begin
            state_reg   <= ST_CLOSED;                    // R7
            win_cnt_reg <= 8'h00;
          end else if (window_done(tick_reg, win_cnt_reg,
                                   OPEN_TICKS)) begin
            reset_out_reg <= 1'b0;                       // R9
            state_reg     <= ST_DELAY;                   // R13
            win_cnt_reg   <= 8'h00;
          end else if (tick_reg) begin
            win_cnt_reg <= win_cnt_reg + 8'h01;
          end
        end
        ST_CLOSED: begin
          if (low_fail_reg || high_fail_reg) begin
            reset_out_reg <= 1'b0;                       // R3
            state_reg     <= ST_WAIT_LOW;
          end else if (tb_off) begin
            state_reg <= ST_WD_OFF;                      // R5
          end else if (trigger) begin
            reset_out_reg <= 1'b0;                       // R8
            state_reg     <= ST_DELAY;                   // R13
            win_cnt_reg   <= 8'h00;
          end else if (window_done(tick_reg, win_cnt_reg,
                                   CLOSED_TICKS)) begin
            state_reg   <= ST_OPEN;                      // R9 R11
            win_cnt_reg <= 8'h00;
          end else if (tick_reg) begin
            win_cnt_reg <= win_cnt_reg + 8'h01;          // R12
          end
        end
        ST_WD_OFF: begin
          win_cnt_reg <= 8'h00;
          if (low_fail_reg || high_fail_reg) begin
            reset_out_reg <= 1'b0;                       // R3
            state_reg     <= ST_WAIT_LOW;
          end else if (!tb_off) begin
            state_reg <= ST_IGNORE;
          end
        end
        default: begin
          reset_out_reg <= 1'b0;
          win_cnt_reg   <= 8'h00;
          state_reg     <= ST_WAIT_LOW;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Status pulses
  // ---------------------------------------------------------------
  // Same conditions as the state machine, so a pulse marks each cause
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_reg      <= '0;
      power_fail_reg <= 1'b0;
    end else begin
      power_fail_reg <= reset_out_reg && (low_fail_reg || high_fail_reg);
      fault_reg.premature <= (state_reg == ST_CLOSED) && !tb_off &&
                             !low_fail_reg && !high_fail_reg &&
                             trigger;                    // R8
      fault_reg.timeout   <= (state_reg == ST_OPEN) && !tb_off &&
                             !low_fail_reg && !high_fail_reg &&
                             !trigger &&
                             window_done(tick_reg, win_cnt_reg,
                                         OPEN_TICKS);    // R9
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign o_reset_out    = reset_out_reg;
  assign o_window_state = state_reg;
  assign o_wd_fault     = fault_reg;
  assign o_power_fail   = power_fail_reg;

endmodule : reset_and_window_watchdog

// ### design/trigger_sampler.sv
// Trigger input sampler and falling-edge pattern decoder
module trigger_sampler
  import wd_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_sample_tick,
  input  wire logic i_trigger_level,
  output logic      o_trigger
);

  // ---------------------------------------------------------------
  // Sample history
  // ---------------------------------------------------------------
  logic [HIST_W-1:0] hist_reg;
  logic [HIST_W-1:0] hist_next;
  logic              trigger_reg;

  // New history as it will stand after this tick
  assign hist_next = {hist_reg[HIST_W-2:0], i_trigger_level};

  // Shift one sample in per tick; starts all low like the idle pin, so
  // no false edge follows reset
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hist_reg <= 4'h0;
    end else if (i_sample_tick) begin
      hist_reg <= hist_next;
    end
  end

  // Pulse one cycle after the tick that takes the second low sample
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      trigger_reg <= 1'b0;
    end else begin
      trigger_reg <= i_sample_tick && (hist_next == TRIG_PATTERN); // R10
    end
  end

  assign o_trigger = trigger_reg;

endmodule : trigger_sampler

// ### inc/wd_pkg.sv
// Shared constants and types for the reset and window watchdog block
package wd_pkg;

  // ---------------------------------------------------------------
  // Clock and timebase
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS     = 5;
  localparam int SAMPLE_PERIOD_NS  = 250_000;
  localparam int SAMPLE_CYCLES     = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int SLOW_FACTOR       = 4;
  localparam int PRESCALE_W        = 20;

  // ---------------------------------------------------------------
  // Window and delay times, fast timing, counted in sample ticks
  // ---------------------------------------------------------------
  localparam int RESET_DELAY_MS    = 8;
  localparam int IGNORE_WINDOW_MS  = 32;
  localparam int OPEN_WINDOW_MS    = 32;
  localparam int CLOSED_WINDOW_MS  = 32;
  localparam int NS_PER_MS         = 1_000_000;
  localparam int TICK_W            = 8;
  localparam logic [TICK_W-1:0] RESET_DELAY_TICKS =
    TICK_W'(RESET_DELAY_MS * NS_PER_MS / SAMPLE_PERIOD_NS);
  localparam logic [TICK_W-1:0] IGNORE_TICKS =
    TICK_W'(IGNORE_WINDOW_MS * NS_PER_MS / SAMPLE_PERIOD_NS);
  localparam logic [TICK_W-1:0] OPEN_TICKS =
    TICK_W'(OPEN_WINDOW_MS * NS_PER_MS / SAMPLE_PERIOD_NS);
  localparam logic [TICK_W-1:0] CLOSED_TICKS =
    TICK_W'(CLOSED_WINDOW_MS * NS_PER_MS / SAMPLE_PERIOD_NS);

  // ---------------------------------------------------------------
  // Supply fail filter
  // ---------------------------------------------------------------
  localparam int REACTION_TIME_NS  = 10_000;
  localparam int REACT_W           = 12;
  localparam logic [REACT_W-1:0] REACTION_CYCLES =
    REACT_W'(REACTION_TIME_NS / CLK_PERIOD_NS);

  // ---------------------------------------------------------------
  // Trigger decode: oldest sample in the top bit
  // ---------------------------------------------------------------
  localparam int HIST_W = 4;
  localparam logic [HIST_W-1:0] TRIG_PATTERN = 4'hC;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [6:0] {
    ST_WAIT_LOW    = 7'h01,
    ST_DELAY       = 7'h02,
    ST_CHECK_HIGH  = 7'h04,
    ST_IGNORE      = 7'h08,
    ST_OPEN        = 7'h10,
    ST_CLOSED      = 7'h20,
    ST_WD_OFF      = 7'h40
  } wd_state_e;

  // Supply comparator results, high when the output is at threshold
  typedef struct packed {
    logic low_supply_good;
    logic high_supply_good;
  } supply_status_s;

  // Decoded level of the timebase select pin
  typedef struct packed {
    logic wd_off;
    logic fast;
  } timebase_select_s;

  // Watchdog failure pulses
  typedef struct packed {
    logic premature;
    logic timeout;
  } wd_fault_s;

endpackage : wd_pkg

// ### verification/mcu_model.sv
// Microcontroller model that drives the watchdog trigger pin
module mcu_model
(
  input  wire logic        i_clk,
  input  wire logic        i_reset_out,
  input  wire logic        i_fire,
  input  wire logic [15:0] i_hold,
  output logic             o_trigger
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] left_reg = 16'h0000;

  // Pin rises for i_hold cycles; the fall after it is the trigger.
  // A part held in reset cannot service its watchdog.
  always @(posedge i_clk) begin
    if (i_fire && i_reset_out) begin
      o_trigger <= 1'b1;
      left_reg  <= i_hold;
    end else if (left_reg > 16'h0001) begin
      left_reg <= left_reg - 16'h0001;
    end else begin
      o_trigger <= 1'b0;
      left_reg  <= 16'h0000;
    end
  end
endmodule : mcu_model

// ### verification/reset_and_window_watchdog_tb_top.sv
// Self-checking bench of the reset and window watchdog block
module reset_and_window_watchdog_tb_top import wd_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int P = 8;
  logic             clk;
  logic             resetn;
  supply_status_s   supply;
  timebase_select_s tsel;
  logic             trig;
  logic             fire;
  logic [15:0]      hold;
  logic             reset_out;
  wd_state_e        state;
  wd_fault_s        fault;
  logic             power_fail;
  logic             pf_seen = 1'b0;
  logic [1:0]       last_fault = 2'b00;
  int               error_cnt;
  int               total_checks;
  int               n;
  int               t;

  reset_and_window_watchdog #(.P_SAMPLE_CYCLES(P)) DUT (
    .i_clk(clk), .i_resetn(resetn), .i_supply(supply),
    .i_timebase_select(tsel), .i_wd_trigger_in(trig),
    .o_reset_out(reset_out), .o_window_state(state),
    .o_wd_fault(fault), .o_power_fail(power_fail));
  mcu_model mcu (.i_clk(clk), .i_reset_out(reset_out), .i_fire(fire),
    .i_hold(hold), .o_trigger(trig));

  // ------------------------------------------------------------
  // Clock, fail record and helpers
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Sticky, since the fail pulse lasts one cycle only
  always @(posedge clk) if (power_fail === 1'b1) pf_seen <= 1'b1;
  // Last fault cause kept, the pulse is gone before the bench looks
  always @(posedge clk) if ((|fault) === 1'b1) last_fault <= fault;

  function automatic logic [6:0] fits(input int v, lo, hi);
    return 7'(v >= lo && v <= hi);
  endfunction : fits
  task automatic chk(input logic [6:0] got, exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : chk
  task automatic idle(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask : idle
  // Bounded wait for a state; n keeps the cycles it took
  task automatic wait_st(input wd_state_e st, input int max);
    n = 0;
    while (state !== st && n < max) begin
      idle(1);
      n++;
    end
    chk(state, st, "state");
  endtask : wait_st
  task automatic kick(input int len);
    @(posedge clk);
    fire <= 1'b1;
    hold <= 16'(len);
    idle(1);
    fire <= 1'b0;
  endtask : kick
  task automatic set_sup(input logic lo, hi);
    @(posedge clk);
    supply <= supply_status_s'({lo, hi});
    #1;
  endtask : set_sup
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done

  initial begin
    idle(50000);
    error_cnt++;
    $display("wrong value at %0t: run too long", $time);
    test_done();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    supply = '0;
    tsel = '{wd_off: 1'b0, fast: 1'b1};
    fire = 1'b0;
    hold = 16'h0000;
    error_cnt = 0;
    total_checks = 0;
    t = P;
    void'($urandom(69955));
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    idle(5);
    set_sup(1'b1, 1'b0);
    wait_st(ST_CHECK_HIGH, 400);
    chk(fits(n, 31 * P - 2, 32 * P + 8), 7'h1, "delay");
    idle(20);
    chk(7'(reset_out), 7'h0, "early release");
    set_sup(1'b1, 1'b1);
    wait_st(ST_IGNORE, 10);
    chk(7'(reset_out), 7'h1, "release");
    kick(3 * t);
    idle(6 * t);
    chk(state, ST_IGNORE, "ignore");
    wait_st(ST_OPEN, 130 * t);
    kick(t - 2);
    idle(6 * t);
    chk(state, ST_OPEN, "short pulse");
    // Random service points, 2 to 90 ticks into the open window
    repeat (3) begin
      idle(t * $urandom_range(2, 90));
      kick(3 * t);
      wait_st(ST_CLOSED, 7 * t);
      wait_st(ST_OPEN, 130 * t);
    end
    kick(3 * t);
    wait_st(ST_CLOSED, 7 * t);
    idle(t * $urandom_range(5, 60));
    kick(3 * t);
    wait_st(ST_DELAY, 7 * t);
    chk(7'(reset_out), 7'h0, "premature");
    wait_st(ST_IGNORE, 40 * t);
    chk(7'(last_fault), 7'h2, "premature cause");
    wait_st(ST_OPEN, 130 * t);
    wait_st(ST_DELAY, 130 * t);
    chk(fits(n, 127 * t - 2, 128 * t + 8), 7'h1, "open time");
    chk(7'(reset_out), 7'h0, "timeout");
    wait_st(ST_IGNORE, 40 * t);
    chk(7'(last_fault), 7'h1, "timeout cause");
    @(posedge clk);
    tsel.wd_off <= 1'b1;
    #1;
    wait_st(ST_WD_OFF, 10);
    kick(3 * t);
    idle(140 * t);
    chk(state, ST_WD_OFF, "wd off");
    chk(7'(reset_out), 7'h1, "wd off reset");
    set_sup(1'b1, 1'b0);
    idle($urandom_range(100, 1900));
    set_sup(1'b1, 1'b1);
    idle(10);
    chk(7'(pf_seen), 7'h0, "glitch");
    chk(7'(reset_out), 7'h1, "glitch reset");
    set_sup(1'b0, 1'b1);
    idle($urandom_range(2100, 2600));
    chk(7'(pf_seen), 7'h1, "fail flag");
    chk(7'(reset_out), 7'h0, "fail reset");
    // Slow timing stretches every window by four
    @(posedge clk);
    tsel <= '{wd_off: 1'b0, fast: 1'b0};
    supply <= supply_status_s'(2'b11);
    #1;
    t = 4 * P;
    wait_st(ST_IGNORE, 40 * t);
    wait_st(ST_OPEN, 130 * t);
    chk(fits(n, 127 * t - 2, 128 * t + 8), 7'h1, "slow");
    kick(3 * t);
    wait_st(ST_CLOSED, 7 * t);
    // Disable inside a running window, then re-enable from the off state
    @(posedge clk);
    tsel.wd_off <= 1'b1;
    #1;
    wait_st(ST_WD_OFF, 10);
    chk(7'(reset_out), 7'h1, "off in window");
    @(posedge clk);
    tsel.wd_off <= 1'b0;
    #1;
    wait_st(ST_IGNORE, 10);
    test_done();
  end
endmodule : reset_and_window_watchdog_tb_top

// ### verification/wd_chk.sv
// Checker of reset sequencing and watchdog window timing
module wd_chk
  import wd_pkg::*;
#(
  parameter int P_SAMPLE_CYCLES = 8
)
(
  input wire logic             i_clk,
  input wire logic             i_resetn,
  input wire supply_status_s   i_supply,
  input wire timebase_select_s i_timebase_select,
  input wire logic             i_wd_trigger_in,
  input wire logic             o_reset_out,
  input wire wd_state_e        o_window_state,
  input wire wd_fault_s        o_wd_fault,
  input wire logic             o_power_fail
);
  timeunit 1ns;
  timeprecision 100ps;
  // ------------------------------------------------------------
  // Time spent in the current state
  // ------------------------------------------------------------
  // Bounds span fast and slow timing, since the mode is read live
  localparam int DLY_MIN = 31 * P_SAMPLE_CYCLES - 2;
  localparam int DLY_MAX = 32 * SLOW_FACTOR * P_SAMPLE_CYCLES + 8;
  localparam int WIN_MIN = 127 * P_SAMPLE_CYCLES - 2;
  localparam int WIN_MAX = 128 * SLOW_FACTOR * P_SAMPLE_CYCLES + 8;
  logic [15:0] held_reg;

  // Saturates so a long supply outage cannot wrap it
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) held_reg <= 16'h0000;
    else if ($changed(o_window_state)) held_reg <= 16'h0001;
    else if (held_reg != 16'hFFFF) held_reg <= held_reg + 16'h0001;
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  // One state left for another at this edge
  sequence s_step(from, to);
    $past(o_window_state) == from && o_window_state == to;
  endsequence

  a_delay_low: assert property (
    o_window_state == ST_DELAY |-> !o_reset_out)
    else $error("reset high during delay");
  a_delay_len: assert property (
    s_step(ST_DELAY, ST_CHECK_HIGH) |-> held_reg >= DLY_MIN
    && held_reg <= DLY_MAX) else $error("delay length off");
  a_release_src: assert property (
    $rose(o_reset_out) |-> $past(o_window_state) == ST_CHECK_HIGH)
    else $error("release outside supply check");
  a_ignore_len: assert property (
    s_step(ST_IGNORE, ST_OPEN) |-> held_reg >= WIN_MIN
    && held_reg <= WIN_MAX) else $error("ignore length off");
  a_closed_len: assert property (
    s_step(ST_CLOSED, ST_OPEN) |-> held_reg >= WIN_MIN
    && held_reg <= WIN_MAX) else $error("closed length off");
  a_premature_src: assert property (
    o_wd_fault.premature |-> !o_reset_out && ($past(o_window_state)
    == ST_CLOSED || $past(o_window_state, 2) == ST_CLOSED))
    else $error("premature fault not from closed window");
  a_timeout_src: assert property (
    o_wd_fault.timeout |-> !o_reset_out && ($past(o_window_state)
    == ST_OPEN || $past(o_window_state, 2) == ST_OPEN))
    else $error("timeout fault not from open window");
  a_fault_delay: assert property (
    (|o_wd_fault) |-> o_window_state == ST_DELAY)
    else $error("fault without reset delay");
  a_off_quiet: assert property (
    o_window_state == ST_WD_OFF |-> o_reset_out && !(|o_wd_fault))
    else $error("watchdog acts while off");
  a_fail_drop: assert property (
    o_power_fail |-> ##[0:2] (!o_reset_out
    && o_window_state == ST_WAIT_LOW)) else $error("fail kept reset");
endmodule : wd_chk

bind reset_and_window_watchdog wd_chk #(
  .P_SAMPLE_CYCLES(P_SAMPLE_CYCLES)) u_chk (
  .i_clk(i_clk), .i_resetn(i_resetn), .i_supply(i_supply),
  .i_timebase_select(i_timebase_select),
  .i_wd_trigger_in(i_wd_trigger_in), .o_reset_out(o_reset_out),
  .o_window_state(o_window_state), .o_wd_fault(o_wd_fault),
  .o_power_fail(o_power_fail));
